// >>> rtl/led_strobe_pin_control.sv
// Contract
// - strobe low forces all sinks off
// - strobe high enables sinks at selected level
// - select low flash, select high video
// - select high disables video watchdog
// - mask high drops flash to video level
// - reset low: shutdown, registers cleared
// - reset high: run under serial commands
// - dual pin: gpio, open-drain or push-pull
// - dual pin defaults to open-drain power-good
`timescale 1ns/1ps
`default_nettype none
module led_strobe_pin_control
    import strobe_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // camera strobe pins
    input wire logic STROBE_ENABLE_INPUT,
    input wire logic LEVEL_SELECT_INPUT,
    input wire logic TX_MASK_INPUT,
    input wire logic HW_RESET_N,
    // settings written over the serial interface
    input wire logic CMD_WRITE,
    input wire logic [7:0] CMD_DATA,
    input wire logic [1:0] CMD_PIN_MODE,
    input wire logic CMD_GPIO_VALUE,
    // analog status
    input wire logic OUTPUT_IN_REGULATION,
    input wire logic WATCHDOG_EXPIRED,
    // dual-purpose pin
    input wire logic GENERAL_PIN_OR_POWER_GOOD_IN,
    output logic GENERAL_PIN_OR_POWER_GOOD_OUT,
    output logic GENERAL_PIN_OR_POWER_GOOD_OE,
    // current sinks and status
    output logic CURRENT_SINK_A,
    output logic CURRENT_SINK_B,
    output logic CURRENT_SINK_C,
    output logic [1:0] LED_LEVEL,
    output logic WATCHDOG_ENABLE,
    output logic SHUTDOWN,
    output logic [7:0] CTRL_IMAGE,
    output logic GPIO_READ
);
    import strobe_pkg::*;

    // three groups of state: the serial-interface image and pin setup,
    // the sink enable with its level and watchdog, and the dual pin;
    // each has its own next-value process and its own register stage
    logic [7:0] ctrl, next_ctrl;
    logic [1:0] pin_mode, next_pin_mode;
    logic gpio_value, next_gpio_value;
    logic sink_on, next_sink_on;
    level_e level, next_level;
    logic wdog_en, next_wdog_en;
    logic shut, next_shut;
    logic wdog_stop, next_wdog_stop;
    logic pin_out, next_pin_out;
    logic pin_oe, next_pin_oe;
    logic gpio_rd, next_gpio_rd;

    // level selection; mask wins over flash only while it is high,
    // so releasing it before any watchdog lapse returns straight to flash without a new strobe
    function automatic level_e pick_level(input logic sel, input logic mask);
        if (sel) begin
            pick_level = LVL_VIDEO;
        end else if (mask) begin
            pick_level = LVL_VIDEO;
        end else begin
            pick_level = LVL_FLASH;
        end
    endfunction

    // serial-interface image and pin setup; the hardware reset wins
    // over a write in the same cycle, so no write lands while the
    // reset pin is low
    always_comb begin
        next_ctrl = ctrl;
        next_pin_mode = pin_mode;
        next_gpio_value = gpio_value;
        if (!HW_RESET_N) begin
            next_ctrl = CTRL_RESET;
            next_pin_mode = PIN_MODE_RESET;
            next_gpio_value = 1'b0;
        end else if (CMD_WRITE) begin
            next_ctrl = CMD_DATA;
            next_pin_mode = CMD_PIN_MODE;
            next_gpio_value = CMD_GPIO_VALUE;
        end
    end

    // sink enable, level and video watchdog; the stop flag is sticky
    // so a lapsed watchdog cannot be undone by the mask toggling,
    // only a dropped strobe, a reset or select going high lets the light come back
    always_comb begin
        next_sink_on = 1'b0;
        next_level = LVL_OFF;
        next_shut = 1'b1;
        next_wdog_stop = wdog_stop;
        next_wdog_en = 1'b0;
        if (!HW_RESET_N) begin
            next_wdog_stop = 1'b0;
        end else begin
            next_shut = 1'b0;
            if (STROBE_ENABLE_INPUT) begin
                next_level = pick_level(LEVEL_SELECT_INPUT, TX_MASK_INPUT);
                // a lapsed watchdog during masked video ends select-low light until strobe drops
                if (next_level == LVL_VIDEO && !LEVEL_SELECT_INPUT &&
                    WATCHDOG_EXPIRED) begin
                    next_wdog_stop = 1'b1;
                end
                next_sink_on = !(next_wdog_stop && !LEVEL_SELECT_INPUT);
                if (!next_sink_on) begin
                    next_level = LVL_OFF;
                end
                next_wdog_en = next_sink_on && !LEVEL_SELECT_INPUT;
            end else begin
                next_wdog_stop = 1'b0;
            end
        end
    end

    // dual-purpose pin drive; open-drain only pulls low when not good
    // the decode follows the mode being loaded, so a new setting shows
    // on the pin one cycle after its write, like every other output
    always_comb begin
        next_pin_out = 1'b0;
        next_pin_oe = 1'b0;
        next_gpio_rd = GENERAL_PIN_OR_POWER_GOOD_IN;
        case (next_pin_mode)
            PIN_MODE_OPEN_DRAIN: begin
                next_pin_oe = !OUTPUT_IN_REGULATION;
            end
            PIN_MODE_PUSH_PULL: begin
                next_pin_out = OUTPUT_IN_REGULATION;
                next_pin_oe = 1'b1;
            end
            PIN_MODE_GPIO_OUT: begin
                next_pin_out = next_gpio_value;
                next_pin_oe = 1'b1;
            end
            default: begin
                next_pin_oe = 1'b0;
            end
        endcase
    end

    // configuration registers
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl <= CTRL_RESET;
            pin_mode <= PIN_MODE_RESET;
            gpio_value <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            pin_mode <= next_pin_mode;
            gpio_value <= next_gpio_value;
        end
    end

    // sink registers; shutdown is also held through the system reset
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sink_on <= 1'b0;
            level <= LVL_OFF;
            wdog_en <= 1'b0;
            shut <= 1'b1;
            wdog_stop <= 1'b0;
        end else begin
            sink_on <= next_sink_on;
            level <= next_level;
            wdog_en <= next_wdog_en;
            shut <= next_shut;
            wdog_stop <= next_wdog_stop;
        end
    end

    // pin registers; the pin sample lags the pin by one cycle
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            gpio_rd <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            gpio_rd <= next_gpio_rd;
        end
    end

    // all three sinks share one enable; analog sets per-sink current
    assign CURRENT_SINK_A = sink_on;
    assign CURRENT_SINK_B = sink_on;
    assign CURRENT_SINK_C = sink_on;
    assign LED_LEVEL = level;
    assign WATCHDOG_ENABLE = wdog_en;
    assign SHUTDOWN = shut;
    assign CTRL_IMAGE = ctrl;
    assign GENERAL_PIN_OR_POWER_GOOD_OUT = pin_out;
    assign GENERAL_PIN_OR_POWER_GOOD_OE = pin_oe;
    assign GPIO_READ = gpio_rd;
endmodule
`default_nettype wire

// >>> rtl/strobe_pkg.sv
package strobe_pkg;
    // current level encoding on the level output
    typedef enum logic [1:0] {LVL_OFF, LVL_FLASH, LVL_VIDEO} level_e;
    // dual-purpose pin configuration codes
    localparam logic [1:0] PIN_MODE_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] PIN_MODE_PUSH_PULL = 2'h1;
    localparam logic [1:0] PIN_MODE_GPIO_OUT = 2'h2;
    localparam logic [1:0] PIN_MODE_GPIO_IN = 2'h3;
    localparam logic [1:0] PIN_MODE_RESET = PIN_MODE_OPEN_DRAIN;
    // serial-interface register image reset value
    localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// >>> tb/cam_host.sv
`timescale 1ns/1ps
`default_nettype none
module cam_host (
    // clock
    input wire logic clk,
    // wanted levels: strobe, select, mask, reset_n
    input wire logic [3:0] req,
    // levels on the driver's pins
    output logic [3:0] pins
);
    // pins move only just after an edge, like a host's own flops
    always_ff @(posedge clk) begin
        pins <= req;
    end
endmodule
`default_nettype wire

// >>> tb/strobe_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module strobe_checker
    import strobe_pkg::*;
(
    // clock, reset and pins
    input wire logic SYS_CLK, SRST, STROBE_ENABLE_INPUT, LEVEL_SELECT_INPUT,
    input wire logic TX_MASK_INPUT, HW_RESET_N, CMD_WRITE, WATCHDOG_EXPIRED,
    input wire logic [7:0] CMD_DATA,
    input wire logic [1:0] CMD_PIN_MODE,
    input wire logic OUTPUT_IN_REGULATION, GENERAL_PIN_OR_POWER_GOOD_OE,
    // driver outputs
    input wire logic CURRENT_SINK_A, CURRENT_SINK_B, CURRENT_SINK_C,
    input wire logic [1:0] LED_LEVEL,
    input wire logic WATCHDOG_ENABLE, SHUTDOWN,
    input wire logic [7:0] CTRL_IMAGE
);
    logic [1:0] pmode;
    wire go = STROBE_ENABLE_INPUT && HW_RESET_N && !WATCHDOG_EXPIRED;
    wire all_on = CURRENT_SINK_A && CURRENT_SINK_B && CURRENT_SINK_C;
    wire any_on = CURRENT_SINK_A || CURRENT_SINK_B || CURRENT_SINK_C;
    // shadow of the pin mode, cleared by either reset
    always_ff @(posedge SYS_CLK) begin
        if (SRST || !HW_RESET_N) pmode <= PIN_MODE_RESET;
        else if (CMD_WRITE) pmode <= CMD_PIN_MODE;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    sinks_off_a: assert property (!STROBE_ENABLE_INPUT |=>
        !any_on && LED_LEVEL == LVL_OFF) else $error("sinks on, no strobe");
    flash_on_a: assert property (go && !LEVEL_SELECT_INPUT &&
        !TX_MASK_INPUT |=> all_on && LED_LEVEL == LVL_FLASH)
        else $error("flash level missing");
    video_sel_a: assert property (go && LEVEL_SELECT_INPUT |=>
        LED_LEVEL == LVL_VIDEO) else $error("video level missing");
    wdog_off_a: assert property (LEVEL_SELECT_INPUT |=>
        !WATCHDOG_ENABLE) else $error("watchdog runs with select high");
    mask_video_a: assert property (go && TX_MASK_INPUT |=>
        LED_LEVEL == LVL_VIDEO) else $error("mask ignored");
    mask_back_a: assert property ($fell(TX_MASK_INPUT) && go &&
        !LEVEL_SELECT_INPUT |=> LED_LEVEL == LVL_FLASH)
        else $error("flash not restored");
    hw_reset_a: assert property (!HW_RESET_N |=> SHUTDOWN && !any_on &&
        CTRL_IMAGE == CTRL_RESET) else $error("hardware reset ignored");
    cmd_load_a: assert property (HW_RESET_N && CMD_WRITE |=>
        CTRL_IMAGE == $past(CMD_DATA)) else $error("command not loaded");
    od_pin_a: assert property (pmode == PIN_MODE_OPEN_DRAIN &&
        HW_RESET_N && !CMD_WRITE |=> GENERAL_PIN_OR_POWER_GOOD_OE ==
        !$past(OUTPUT_IN_REGULATION)) else $error("open-drain pin wrong");
    cover property (go && TX_MASK_INPUT);
    cover property (go && LEVEL_SELECT_INPUT);
    wdog_trip_a: assert property (STROBE_ENABLE_INPUT && HW_RESET_N &&
        !LEVEL_SELECT_INPUT && TX_MASK_INPUT && WATCHDOG_EXPIRED |=>
        !any_on) else $error("watchdog lapse ignored");
    cover property (HW_RESET_N && CMD_WRITE);
    cover property (STROBE_ENABLE_INPUT && WATCHDOG_EXPIRED);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import strobe_pkg::*;
    logic sys_clk = 0, srst = 1, wr_en = 0, reg_ok = 0;
    logic [7:0] data = 8'h00, ctl;
    logic [1:0] mode = 2'h0, lvl;
    logic [3:0] req = 4'h1;
    logic [3:0] pins;
    logic sa, sb, sc, oe, po, wde, sd, grd;
    logic gv = 0, pin_in = 0, wexp = 0;
    int n_fail = 0, compares = 0;
    // 25 MHz system clock
    always #20 sys_clk = ~sys_clk;
    cam_host host (.clk(sys_clk), .req(req), .pins(pins));
    led_strobe_pin_control dut (.SYS_CLK(sys_clk), .SRST(srst),
        .STROBE_ENABLE_INPUT(pins[3]), .LEVEL_SELECT_INPUT(pins[2]),
        .TX_MASK_INPUT(pins[1]), .HW_RESET_N(pins[0]), .CMD_WRITE(wr_en),
        .CMD_DATA(data), .CMD_PIN_MODE(mode), .CMD_GPIO_VALUE(gv),
        .OUTPUT_IN_REGULATION(reg_ok), .WATCHDOG_EXPIRED(wexp),
        .GENERAL_PIN_OR_POWER_GOOD_IN(pin_in),
        .GENERAL_PIN_OR_POWER_GOOD_OUT(po),
        .GENERAL_PIN_OR_POWER_GOOD_OE(oe), .CURRENT_SINK_A(sa),
        .CURRENT_SINK_B(sb), .CURRENT_SINK_C(sc), .LED_LEVEL(lvl),
        .WATCHDOG_ENABLE(wde), .SHUTDOWN(sd), .CTRL_IMAGE(ctl),
        .GPIO_READ(grd));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // host pins take one edge, the driver another
    task automatic step(input logic [3:0] v);
        @(posedge sys_clk) req <= v;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d, input logic [1:0] m);
        @(posedge sys_clk) {wr_en, data, mode} <= {1'b1, d, m};
        @(posedge sys_clk) wr_en <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic t_levels();
        step(4'b1001);
        check(8'(lvl), 8'(LVL_FLASH));
        check(8'({sa, sb, sc}), 8'h07);
        step(4'b1101);
        check(8'(lvl), 8'(LVL_VIDEO));
        check(8'(wde), 8'h00);
        step(4'b1011);
        check(8'(lvl), 8'(LVL_VIDEO));
        step(4'b1001);
        check(8'(lvl), 8'(LVL_FLASH));
        step(4'b0011);
        check(8'({sa, sb, sc, lvl}), 8'h00);
    endtask
    task automatic t_pins();
        check(8'(oe), 8'h01);
        @(posedge sys_clk) reg_ok <= 1'b1;
        wr(8'hA5, PIN_MODE_PUSH_PULL);
        check(ctl, 8'hA5);
        check(8'({oe, po}), 8'h03);
        step(4'b1000);
        check(8'({sd, sa, sb, sc}), 8'h08);
        check(ctl, CTRL_RESET);
        wr(8'h5A, PIN_MODE_GPIO_OUT);
        check(ctl, CTRL_RESET);
        step(4'b0001);
        check(8'(oe), 8'h00);
    endtask
    // gpio out drives the written value, gpio in samples the pin
    task automatic t_gpio();
        @(posedge sys_clk) {gv, pin_in} <= 2'b11;
        wr(8'h3C, PIN_MODE_GPIO_OUT);
        check(8'({oe, po}), 8'h03);
        wr(8'hC3, PIN_MODE_GPIO_IN);
        check(8'({oe, grd}), 8'h01);
    endtask
    // masked video runs the watchdog; a lapse ends it until strobe drops
    task automatic t_wdog();
        step(4'b1011);
        check(8'({wde, lvl}), 8'h06);
        @(posedge sys_clk) wexp <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(8'({sa, lvl}), 8'h00);
        step(4'b0011);
        @(posedge sys_clk) wexp <= 1'b0;
        step(4'b1011);
        check(8'({sa, wde, lvl}), 8'h0E);
    endtask
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // reset for five edges, then the scenarios
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        step(4'b0001);
        t_pins();
        t_levels();
        t_gpio();
        t_wdog();
        end_of_test();
    end
    // hang guard, far beyond the few dozen cycles needed
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
endmodule
bind led_strobe_pin_control strobe_checker chk (.*);
`default_nettype wire
